// ### design/lshp_als_report.sv
// Ambient light result path: overflow mapping, threshold window, interrupt
// source. Assumes a one-cycle sample strobe from the converter side.
`timescale 1ns/1ns
`default_nettype none
`include "lshp_map.svh"
module lshp_als_report (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        sampleValid,
   input  wire logic        sampleIr,
   input  wire logic [15:0] sampleData,
   input  wire logic        sampleSat,
   input  wire logic        irEnable,
   input  wire logic        everySample,
   input  wire logic        windowOnIr,
   input  wire logic [15:0] thrLow,
   input  wire logic [15:0] thrHigh,
   output var  logic [15:0] visResult,
   output var  logic [15:0] irResult,
   output logic             resultEvent,
   output logic             alsIrq
);
   logic [15:0] value;
   logic        take;
   logic        onWindow;
   logic        outside;
   // Saturated samples report full scale; not held across samples
   assign value    = sampleSat ? `LSHP_RESULT_OVF : sampleData;
   // IR samples are dropped while the channel is deselected
   assign take     = sampleValid && (!sampleIr || irEnable);
   assign onWindow = (sampleIr == windowOnIr);
   assign outside  = (value < thrLow) || (value > thrHigh);
   assign resultEvent = take;
   assign alsIrq   = take && (everySample || (onWindow && outside));

   always_ff @(posedge clk) begin
      if (!rstn) begin
         visResult <= 16'h0000;
         irResult  <= 16'h0000;
      end else if (take && sampleIr) begin
         irResult  <= value;
      end else if (take) begin
         visResult <= value;
      end
   end

   property p_ovf_value;
      @(posedge clk) disable iff (!rstn)
      (take && sampleSat && !sampleIr) |=> visResult == `LSHP_RESULT_OVF;
   endproperty
   a_ovf_value: assert property (p_ovf_value) else $error("no full scale");
   property p_not_held;
      @(posedge clk) disable iff (!rstn)
      (take && !sampleSat && !sampleIr) |=> visResult == $past(sampleData);
   endproperty
   a_not_held: assert property (p_not_held) else $error("result held");
   property p_window_quiet;
      @(posedge clk) disable iff (!rstn)
      (take && !everySample && value >= thrLow && value <= thrHigh)
         |-> !alsIrq;
   endproperty
   a_window_quiet: assert property (p_window_quiet) else $error("irq in win");
   property p_one_channel;
      @(posedge clk) disable iff (!rstn)
      (take && !everySample && sampleIr != windowOnIr) |-> !alsIrq;
   endproperty
   a_one_channel: assert property (p_one_channel) else $error("wrong chan");
   property p_every;
      @(posedge clk) disable iff (!rstn)
      (take && everySample) |-> alsIrq;
   endproperty
   a_every: assert property (p_every) else $error("no sample irq");
   property p_ir_skip;
      @(posedge clk) disable iff (!rstn)
      (sampleValid && sampleIr && !irEnable) |=> $stable(irResult);
   endproperty
   a_ir_skip: assert property (p_ir_skip) else $error("ir not skipped");
   c_irq: cover property (@(posedge clk) alsIrq && !everySample);
endmodule // lshp_als_report
`default_nettype wire

// ### design/lshp_host_port.sv
// Host port of the light sensor: I2C slave with register pointer, open-drain
// interrupt pin, ambient result reporting and conversion configuration.
// Assumes SCL/SDA/INT are pins outside the clock domain; clk well above SCL.
`timescale 1ns/1ns
`default_nettype none
`include "lshp_map.svh"
module lshp_host_port #(
   parameter int RATE_W = 16
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              sclIn,
   input  wire logic              sdaIn,
   output logic                   sdaOut,
   output logic                   sdaOe,
   output logic                   intOut,
   output logic                   intOe,
   // Register file side
   output var  logic [5:0]        regIndex,
   output var  logic [7:0]        regWrData,
   output var  logic              regWrStrobe,
   output logic                   regRdStrobe,
   input  wire logic [7:0]        regRdData,
   output var  logic              gcallReset,
   // Commands and reply
   input  wire logic              cmdValid,
   input  wire logic [7:0]        cmdCode,
   output logic                   cmdAccept,
   output var  logic              replyOverflow,
   // Ambient conversion configuration and results
   input  wire logic              sampleValid,
   input  wire logic              sampleIr,
   input  wire logic [15:0]       sampleData,
   input  wire logic              sampleSat,
   input  wire logic              irEnable,
   input  wire logic              autoMode,
   input  wire logic              everySample,
   input  wire logic              windowOnIr,
   input  wire logic [15:0]       thrLow,
   input  wire logic [15:0]       thrHigh,
   input  wire logic              irqClear,
   input  wire logic [RATE_W-1:0] alsRate,
   input  wire logic [RATE_W-1:0] proxRate,
   input  wire lshp_pkg::lshp_itime_t visItime,
   input  wire lshp_pkg::lshp_itime_t irItime,
   output var  logic [RATE_W-1:0] alsRateOut,
   output var  logic [RATE_W-1:0] proxRateOut,
   output var  logic [31:0]       visItimeCycles,
   output var  logic [31:0]       irItimeCycles,
   output var  logic [15:0]       visResult,
   output var  logic [15:0]       irResult,
   output var  logic              initDone
);
   //****************************************************************
   // Pin sampling
   //****************************************************************
   logic sclS;
   logic sdaS;
   logic sclPrev_r;
   logic sdaPrev_r;
   lshp_sync u_scl (.clk(clk), .rstn(rstn), .pinIn(sclIn), .pinSync(sclS));
   lshp_sync u_sda (.clk(clk), .rstn(rstn), .pinIn(sdaIn), .pinSync(sdaS));

   wire sclRise = sclS && !sclPrev_r;
   wire sclFall = !sclS && sclPrev_r;
   wire startCond = sclS && sclPrev_r && sdaPrev_r && !sdaS;
   wire stopCond  = sclS && sclPrev_r && !sdaPrev_r && sdaS;

   //****************************************************************
   // Byte engine
   //****************************************************************
   lshp_pkg::lshp_bus_t st_r;
   logic [7:0] shift_r;
   logic [3:0] bitCnt_r;
   logic       isRead_r;
   logic       isGcall_r;
   logic       gotPtr_r;
   logic       stepInhibit_r;
   logic       ackDrive_r;
   logic       sdaDrive_r;

   wire [7:0] rxByte = {shift_r[6:0], sdaS};
   wire addrOwn   = rxByte[7:1] == `LSHP_SLAVE_ADDR;
   wire addrGcall = rxByte[7:1] == `LSHP_GCALL_ADDR && !rxByte[0];
   wire byteDone  = sclRise && bitCnt_r == 4'd7;
   wire stepPtr   = !stepInhibit_r;
   // Read byte is fetched on the fall that ends the ack slot, so its first
   // bit stands on SDA before the master raises SCL again
   wire rdLoad    = sclFall && ((st_r == lshp_pkg::LSHP_ACK && ackDrive_r &&
                    isRead_r) || (st_r == lshp_pkg::LSHP_RACK &&
                    bitCnt_r == 4'd0));

   function automatic logic [5:0] nextIndex(input logic [5:0] idx,
                                            input logic step);
      nextIndex = step ? idx + 6'd1 : idx;
   endfunction

   assign sdaOut = 1'b0;
   assign sdaOe  = ackDrive_r || sdaDrive_r;
   assign regRdStrobe = rdLoad;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclPrev_r <= sclS;
         sdaPrev_r <= sdaS;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_r          <= lshp_pkg::LSHP_IDLE;
         shift_r       <= 8'h00;
         bitCnt_r      <= 4'd0;
         isRead_r      <= 1'b0;
         isGcall_r     <= 1'b0;
         gotPtr_r      <= 1'b0;
         stepInhibit_r <= 1'b0;
         ackDrive_r    <= 1'b0;
         sdaDrive_r    <= 1'b0;
         regIndex      <= 6'd0;
         regWrData     <= 8'h00;
         regWrStrobe   <= 1'b0;
         gcallReset    <= 1'b0;
      end else begin
         regWrStrobe <= 1'b0;
         gcallReset  <= 1'b0;
         if (startCond) begin
            st_r       <= lshp_pkg::LSHP_ADDR;
            bitCnt_r   <= 4'd0;
            gotPtr_r   <= 1'b0;
            ackDrive_r <= 1'b0;
            sdaDrive_r <= 1'b0;
         end else if (stopCond) begin
            // Pointer is kept so a later read resumes from it
            st_r       <= lshp_pkg::LSHP_IDLE;
            ackDrive_r <= 1'b0;
            sdaDrive_r <= 1'b0;
         end else begin
            unique case (st_r)
               lshp_pkg::LSHP_IDLE, lshp_pkg::LSHP_SKIP: begin
               end
               lshp_pkg::LSHP_ADDR: begin
                  if (sclRise) begin
                     shift_r  <= rxByte;
                     bitCnt_r <= bitCnt_r + 4'd1;
                  end
                  if (byteDone) begin
                     bitCnt_r  <= 4'd0;
                     isRead_r  <= rxByte[0];
                     isGcall_r <= addrGcall;
                     st_r      <= (addrOwn || addrGcall) ?
                                  lshp_pkg::LSHP_ACK : lshp_pkg::LSHP_SKIP;
                  end
               end
               lshp_pkg::LSHP_ACK: begin
                  // Written byte was strobed on entry; step past it here
                  if (regWrStrobe) begin
                     regIndex <= nextIndex(regIndex, stepPtr);
                  end
                  if (sclFall && !ackDrive_r) begin
                     ackDrive_r <= 1'b1;
                  end else if (sclFall) begin
                     ackDrive_r <= 1'b0;
                     if (isRead_r) begin
                        st_r       <= lshp_pkg::LSHP_RDATA;
                        shift_r    <= regRdData;
                        sdaDrive_r <= !regRdData[7];
                     end else begin
                        st_r <= lshp_pkg::LSHP_WDATA;
                     end
                  end
               end
               lshp_pkg::LSHP_WDATA: begin
                  if (sclRise) begin
                     shift_r  <= rxByte;
                     bitCnt_r <= bitCnt_r + 4'd1;
                  end
                  if (byteDone) begin
                     bitCnt_r <= 4'd0;
                     st_r     <= lshp_pkg::LSHP_ACK;
                     isRead_r <= 1'b0;
                     if (isGcall_r) begin
                        gcallReset <= rxByte == `LSHP_GCALL_RESET;
                     end else if (!gotPtr_r) begin
                        // Pointer load only; no register written
                        gotPtr_r      <= 1'b1;
                        regIndex      <= rxByte[`LSHP_PTR_IDX_MSB:0];
                        stepInhibit_r <= rxByte[`LSHP_PTR_STEP_BIT];
                     end else begin
                        regWrData   <= rxByte;
                        regWrStrobe <= 1'b1;
                     end
                  end
               end
               lshp_pkg::LSHP_RDATA: begin
                  sdaDrive_r <= !shift_r[7] && bitCnt_r < 4'd8;
                  if (sclFall) begin
                     // Next bit goes out on the edge of the shift itself;
                     // waiting a cycle eats most of the SCL low time
                     shift_r    <= {shift_r[6:0], 1'b0};
                     sdaDrive_r <= !shift_r[6];
                     bitCnt_r   <= bitCnt_r + 4'd1;
                     if (bitCnt_r == 4'd7) begin
                        st_r       <= lshp_pkg::LSHP_RACK;
                        sdaDrive_r <= 1'b0;
                        regIndex   <= nextIndex(regIndex, stepPtr);
                     end
                  end
               end
               lshp_pkg::LSHP_RACK: begin
                  // Master NACK ends the burst; ACK loads the next byte
                  if (sclRise) begin
                     bitCnt_r <= 4'd0;
                     if (sdaS) begin
                        st_r <= lshp_pkg::LSHP_SKIP;
                     end
                  end
                  if (rdLoad) begin
                     st_r       <= lshp_pkg::LSHP_RDATA;
                     shift_r    <= regRdData;
                     sdaDrive_r <= !regRdData[7];
                  end
               end
               default: st_r <= lshp_pkg::LSHP_IDLE;
            endcase
         end
      end
   end

   //****************************************************************
   // Interrupt pin, init, overflow reply, configuration
   //****************************************************************
   logic [4:0] initCnt_r;
   logic       irqPend_r;
   logic       alsIrq;
   logic       resultEvent;
   wire        ovfEvent = resultEvent && sampleSat;
   wire        nopCmd   = cmdValid && cmdCode == `LSHP_CMD_NOP;

   // Commands are never refused, even with overflow pending
   assign cmdAccept = cmdValid;
   // Pin stays an input until initialization has completed
   assign intOe  = initDone && irqPend_r;
   assign intOut = 1'b0;

   function automatic logic [31:0] itimeCycles(input lshp_pkg::lshp_itime_t t);
      unique case (t)
         lshp_pkg::LSHP_ITIME_MID:
            itimeCycles = `LSHP_INT_TIME_NS1 / `LSHP_CLK_PERIOD_NS;
         lshp_pkg::LSHP_ITIME_LONG:
            itimeCycles = `LSHP_INT_TIME_NS2 / `LSHP_CLK_PERIOD_NS;
         default:
            itimeCycles = `LSHP_INT_TIME_NS0 / `LSHP_CLK_PERIOD_NS;
      endcase
   endfunction

   lshp_als_report u_als (
      .clk         (clk),
      .rstn        (rstn),
      .sampleValid (sampleValid),
      .sampleIr    (sampleIr),
      .sampleData  (sampleData),
      .sampleSat   (sampleSat),
      .irEnable    (irEnable),
      .everySample (everySample),
      .windowOnIr  (windowOnIr),
      .thrLow      (thrLow),
      .thrHigh     (thrHigh),
      .visResult   (visResult),
      .irResult    (irResult),
      .resultEvent (resultEvent),
      .alsIrq      (alsIrq)
   );

   always_ff @(posedge clk) begin
      if (!rstn) begin
         initCnt_r      <= 5'd0;
         initDone       <= 1'b0;
         irqPend_r      <= 1'b0;
         replyOverflow  <= 1'b0;
         alsRateOut     <= '0;
         proxRateOut    <= '0;
         visItimeCycles <= `LSHP_INT_TIME_NS0 / `LSHP_CLK_PERIOD_NS;
         irItimeCycles  <= `LSHP_INT_TIME_NS0 / `LSHP_CLK_PERIOD_NS;
      end else begin
         if (!initDone) begin
            initCnt_r <= initCnt_r + 5'd1;
            initDone  <= initCnt_r == 5'(`LSHP_INIT_CYCLES - 1);
         end
         // Set wins over a same-cycle clear
         if (autoMode && alsIrq) begin
            irqPend_r <= 1'b1;
         end else if (irqClear) begin
            irqPend_r <= 1'b0;
         end
         if (ovfEvent) begin
            replyOverflow <= 1'b1;
         end else if (nopCmd) begin
            replyOverflow <= 1'b0;
         end
         alsRateOut     <= alsRate;
         proxRateOut    <= proxRate;
         visItimeCycles <= itimeCycles(visItime);
         irItimeCycles  <= itimeCycles(irItime);
      end
   end

   //****************************************************************
   // Checks
   //****************************************************************
   property p_int_input;
      @(posedge clk) disable iff (!rstn) !initDone |-> !intOe;
   endproperty
   a_int_input: assert property (p_int_input) else $error("int driven early");
   property p_ovf_sticky;
      @(posedge clk) disable iff (!rstn)
      (replyOverflow && !nopCmd) |=> replyOverflow;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("ovf lost");
   property p_ovf_clear;
      @(posedge clk) disable iff (!rstn)
      (nopCmd && !ovfEvent) |=> !replyOverflow;
   endproperty
   a_ovf_clear: assert property (p_ovf_clear) else $error("nop no clear");
   property p_cmd_run;
      @(posedge clk) disable iff (!rstn) cmdValid |-> cmdAccept;
   endproperty
   a_cmd_run: assert property (p_cmd_run) else $error("cmd refused");
   property p_ptr_stop;
      @(posedge clk) disable iff (!rstn) stopCond |=> $stable(regIndex);
   endproperty
   a_ptr_stop: assert property (p_ptr_stop) else $error("ptr moved");
   property p_inhibit;
      @(posedge clk) disable iff (!rstn)
      (st_r == lshp_pkg::LSHP_RDATA && stepInhibit_r && !startCond)
         |=> $stable(regIndex);
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("ptr stepped");
   property p_rd_first;
      @(posedge clk) disable iff (!rstn)
      rdLoad |=> sdaOe == !$past(regRdData[7]);
   endproperty
   a_rd_first: assert property (p_rd_first) else $error("late bit");
   property p_ptr_load;
      @(posedge clk) disable iff (!rstn)
      (st_r == lshp_pkg::LSHP_WDATA && byteDone && !gotPtr_r && !isGcall_r
         && !startCond && !stopCond)
         |=> regIndex == $past(rxByte[5:0]) && !regWrStrobe;
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("ptr not loaded");
   property p_itime;
      @(posedge clk) disable iff (!rstn)
      visItime == lshp_pkg::LSHP_ITIME_SHORT |=> visItimeCycles == 32'd512;
   endproperty
   a_itime: assert property (p_itime) else $error("bad itime");
   c_write: cover property (@(posedge clk) regWrStrobe);
   c_read:  cover property (@(posedge clk) regRdStrobe);
   c_gcall: cover property (@(posedge clk) gcallReset);
   c_ovf:   cover property (@(posedge clk) replyOverflow && nopCmd);
endmodule // lshp_host_port
`default_nettype wire

// ### design/lshp_map.svh
// Constants for the light sensor host port: bus address, pointer fields,
// result values and timing counts. Definitions only; included by name.
`ifndef LSHP_MAP_SVH
`define LSHP_MAP_SVH
`define LSHP_SLAVE_ADDR     7'h5A
`define LSHP_GCALL_ADDR     7'h00
`define LSHP_GCALL_RESET    8'h06
`define LSHP_PTR_IDX_MSB    5
`define LSHP_PTR_STEP_BIT   6
`define LSHP_RESULT_OVF     16'hFFFF
`define LSHP_CMD_NOP        8'h00
`define LSHP_INT_TIME_NS0   25600
`define LSHP_INT_TIME_NS1   410000
`define LSHP_INT_TIME_NS2   3280000
`define LSHP_CLK_PERIOD_NS  50
`define LSHP_INIT_CYCLES    16
`endif

// ### design/lshp_pkg.sv
// Types shared by the light sensor host port files.
// Assumes the map header is compiled alongside.
package lshp_pkg;
   typedef enum logic [2:0] {
      LSHP_IDLE, LSHP_ADDR, LSHP_ACK, LSHP_WDATA, LSHP_RDATA, LSHP_RACK,
      LSHP_SKIP
   } lshp_bus_t;
   typedef enum logic [1:0] {
      LSHP_ITIME_SHORT, LSHP_ITIME_MID, LSHP_ITIME_LONG
   } lshp_itime_t;
endpackage

// ### design/lshp_sync.sv
// Two-flop synchroniser for a pin input.
// Assumes clk is the block clock; the output lags the pin by two edges.
`timescale 1ns/1ns
`default_nettype none
module lshp_sync (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic pinIn,
   output var  logic pinSync
);
   logic firstStage_r;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         firstStage_r <= 1'b1;
         pinSync      <= 1'b1;
      end else begin
         firstStage_r <= pinIn;
         pinSync      <= firstStage_r;
      end
   end
endmodule // lshp_sync
`default_nettype wire

// ### test/lshp_bfm.sv
// Behavioural I2C bus master standing in for the host processor.
// Assumes the bench resolves the pulled-up SDA line and returns it here.
`timescale 1ns/1ns
`default_nettype none
module lshp_bfm (
   output var  logic sclOut,
   output var  logic sdaLow,
   input  wire logic sdaLine
);
   // Quarter of the 400 ns bus clock; SCL stands high between frames
   localparam int Q = 100;
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic bitIo(input logic b, output logic r);
      sdaLow = !b;
      #Q sclOut = 1'b1;
      #Q r = sdaLine;
      #Q sclOut = 1'b0;
      #Q;
   endtask
   // Start when s is high, stop otherwise; SDA changes while SCL is high to mark it
   task automatic frame(input logic s);
      sdaLow = !s;
      #Q sclOut = 1'b1;
      #Q sdaLow = s;
      #Q sclOut = !s;
      #Q;
   endtask
   // Eight data bits then the acknowledge slot; a one releases the line
   task automatic byteIo(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) bitIo(d[i], q[i]);
   endtask
endmodule // lshp_bfm
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the light sensor host port.
// Assumes the port and the bus master model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "lshp_map.svh"
module tb;
   localparam logic [7:0] AW = {`LSHP_SLAVE_ADDR, 1'b0};
   logic clk = 1'b0, rstn = 1'b0, cmdValid = 1'b0, sampleValid = 1'b0;
   logic sampleIr = 1'b0, sampleSat = 1'b0, irEnable = 1'b1, irqClear = 1'b0;
   logic autoMode = 1'b0, everySample = 1'b0, windowOnIr = 1'b0;
   logic [7:0] cmdCode = 8'h00;
   logic [15:0] sampleData = 16'h0000, thrLow = 16'h0064, thrHigh = 16'h00C8;
   logic [15:0] alsRate = 16'h0000, proxRate = 16'h0000;
   lshp_pkg::lshp_itime_t visItime = lshp_pkg::LSHP_ITIME_SHORT;
   lshp_pkg::lshp_itime_t irItime = lshp_pkg::LSHP_ITIME_SHORT;
   wire logic scl, sdaLow, sdaOut, sdaOe, intOut, intOe, regWrStrobe;
   wire logic regRdStrobe, gcallReset, cmdAccept, replyOverflow, initDone;
   wire logic [5:0] regIndex;
   wire logic [7:0] regWrData;
   wire logic [15:0] alsRateOut, proxRateOut, visResult, irResult;
   wire logic [31:0] visItimeCycles, irItimeCycles;
   // Pulled-up open-drain line, low while either party pulls
   wire logic sda = !(sdaLow | sdaOe);
   wire logic [7:0] regRdData = {2'h3, regIndex};
   int errTotal = 0, nChecks = 0, nGcall = 0, nRd = 0;
   logic [13:0] wrLog[$];
   lshp_host_port #(.RATE_W(16)) lshp_host_port_inst (.clk, .rstn,
      .sclIn(scl), .sdaIn(sda), .sdaOut, .sdaOe, .intOut, .intOe, .regIndex,
      .regWrData, .regWrStrobe, .regRdStrobe, .regRdData, .gcallReset,
      .cmdValid, .cmdCode, .cmdAccept, .replyOverflow, .sampleValid, .sampleIr,
      .sampleData, .sampleSat, .irEnable, .autoMode, .everySample, .windowOnIr,
      .thrLow, .thrHigh, .irqClear, .alsRate, .proxRate, .visItime, .irItime,
      .alsRateOut, .proxRateOut, .visItimeCycles, .irItimeCycles, .visResult,
      .irResult, .initDone);
   lshp_bfm lshp_bfm_inst (.sclOut(scl), .sdaLow, .sdaLine(sda));
   // ********
   // Helpers and scenarios
   // ********
   initial forever #25 clk = !clk;
   always @(posedge clk) begin
      if (regWrStrobe === 1'b1) wrLog.push_back({regIndex, regWrData});
      if (gcallReset === 1'b1) nGcall++;
      if (regRdStrobe === 1'b1) nRd++;
   end
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      nChecks++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic xfer(input logic [7:0] b[$], output logic [3:0] acks);
      logic [8:0] q;
      acks = 4'h0;
      lshp_bfm_inst.frame(1'b1);
      foreach (b[i]) begin
         lshp_bfm_inst.byteIo({b[i], 1'b1}, q);
         acks = acks + {3'h0, !q[0]};
      end
      lshp_bfm_inst.frame(1'b0);
   endtask
   // Two-byte read: master acks the first byte and refuses the last
   task automatic rd(input logic [7:0] e0, input logic [7:0] e1);
      logic [8:0] q0, q1, q2;
      lshp_bfm_inst.frame(1'b1);
      lshp_bfm_inst.byteIo({AW | 8'h01, 1'b1}, q0);
      lshp_bfm_inst.byteIo(9'h1FE, q1);
      lshp_bfm_inst.byteIo(9'h1FF, q2);
      lshp_bfm_inst.frame(1'b0);
      chk({q0[0], q1[8:1], q2[8:1]}, {1'b0, e0, e1});
   endtask
   // v high sends a converter sample, low pulses the interrupt clear
   task automatic smp(input logic v, ir, input logic [15:0] d, input logic s);
      {sampleIr, sampleData, sampleSat} = {ir, d, s};
      sampleValid = v;
      irqClear = !v;
      tk(1);
      {sampleValid, irqClear} = 2'b00;
      tk(3);
   endtask
   task automatic tI2c();
      logic [3:0] n;
      xfer({8'h00, `LSHP_GCALL_RESET}, n);
      chk({n, nGcall[3:0]}, {4'h2, 4'h1});
      xfer({8'hB6}, n);
      chk(n, 4'h0);
      xfer({8'hF0}, n);
      chk(n, 4'h0);
      xfer({AW, 8'h05, 8'hAB, 8'hCD}, n);
      tk(4);
      chk({n, wrLog[0], wrLog[1]}, {4'h4, 6'h05, 8'hAB, 6'h06, 8'hCD});
      xfer({AW, 8'h02}, n);
      chk(32'(wrLog.size()), 32'h2);
      rd(8'hC2, 8'hC3);
      rd(8'hC4, 8'hC5);
      xfer({AW, 8'h47}, n);
      rd(8'hC7, 8'hC7);
      chk(nRd[3:0], 4'h6);
   endtask
   task automatic tRes();
      smp(1'b1, 1'b0, 16'h0123, 1'b1);
      chk({visResult, replyOverflow}, {`LSHP_RESULT_OVF, 1'b1});
      {cmdCode, cmdValid} = {8'h11, 1'b1};
      #1 chk(cmdAccept, 1'b1);
      tk(1);
      cmdValid = 1'b0;
      smp(1'b1, 1'b0, 16'h1234, 1'b0);
      chk({visResult, replyOverflow}, {16'h1234, 1'b1});
      {cmdCode, cmdValid} = {`LSHP_CMD_NOP, 1'b1};
      tk(1);
      cmdValid = 1'b0;
      tk(1);
      chk(replyOverflow, 1'b0);
      autoMode = 1'b1;
      smp(1'b1, 1'b0, 16'h0096, 1'b0);
      smp(1'b1, 1'b1, 16'h0032, 1'b0);
      chk({intOe, irResult}, {1'b0, 16'h0032});
      smp(1'b1, 1'b0, 16'h00FA, 1'b0);
      chk({intOe, visResult}, {1'b1, 16'h00FA});
      everySample = 1'b1;
      smp(1'b0, 1'b0, 16'h0000, 1'b0);
      chk(intOe, 1'b0);
      smp(1'b1, 1'b0, 16'h0096, 1'b0);
      chk(intOe, 1'b1);
      {everySample, windowOnIr} = 2'b01;
      smp(1'b0, 1'b0, 16'h0000, 1'b0);
      smp(1'b1, 1'b0, 16'h0010, 1'b0);
      chk(intOe, 1'b0);
      irEnable = 1'b0;
      smp(1'b1, 1'b1, 16'h0010, 1'b0);
      chk({intOe, irResult}, {1'b0, 16'h0032});
   endtask
   initial begin
      tk(10);
      rstn = 1'b1;
      tk(1);
      chk({initDone, intOe, sdaOut, intOut, visItimeCycles},
          {4'h0, 32'h200});
      for (int i = 0; i < 40 && initDone !== 1'b1; i++) tk(1);
      tk(4);
      visItime = lshp_pkg::LSHP_ITIME_MID;
      irItime = lshp_pkg::LSHP_ITIME_LONG;
      {alsRate, proxRate} = 32'h00100020;
      tk(2);
      chk({alsRateOut, proxRateOut}, 32'h00100020);
      chk({visItimeCycles, irItimeCycles}, {32'h2008, 32'h10040});
      tI2c();
      tRes();
      summarize();
   end
   initial begin
      #1000000;
      errTotal++;
      summarize();
   end
endmodule // tb
`default_nettype wire
